// File: src/orbrf_pkg.sv
// Behaviour
// - status 0 when ack complete returned
// - status 1 when packet needs no ack
// - status 2 for ack other than comp/busy X/pending
// - status 3 when no ack returned
// - doorbell response: 4 not queued, 5 queued
// - status 7 when retry limit reached
// - pointer write response: 8 not queued, 9 queued
// - status A when response code not complete
// - status B on split transaction timeout
// - status C when bus reset discards request
// - status D on transaction reset or clear
// - speed 00/01/10, 11 undefined
// - follow-on label of auto fetch, else zero
// - follow-on label only in command fifo
// - store returned acknowledge code in record
// - retry field new/X/A/B as 00..11
// - node address is bus ten, node six
// - priority bits zero for cable operation
// - source id of responder in record
// - orb offset high, low and orb data stored
// - host reads fifos at 84h and 88h
// - short select bits choose shortened record layout
package orbrf_pkg;

    // ****************
    // bus map
    // ****************
    localparam logic [7:0] ADR_FETCH_CTRL = 8'h44;
    localparam logic [7:0] ADR_MGMT_READ  = 8'h84;
    localparam logic [7:0] ADR_CMD_READ   = 8'h88;
    localparam logic [7:0] ADR_TXN_CTRL   = 8'h90;
    localparam logic [7:0] ADR_LEVEL      = 8'hA0;
    localparam int         BIT_MGMT_SHORT = 0;
    localparam int         BIT_CMD_SHORT  = 1;
    localparam int         BIT_CONT_FETCH = 2;
    localparam int         BIT_TXN_RESET  = 0;
    localparam int         BIT_TX_CLEAR   = 1;
    localparam int         POS_CMD_LEVEL  = 16;
    localparam logic [2:0] FETCH_CTRL_RST = 3'h0;

    // ****************
    // record layout
    // ****************
    localparam int         FIFO_DEPTH  = 32;
    localparam int         ORB_QUADS   = 8;
    localparam logic [3:0] LONG_QUADS  = 4'hC;
    localparam logic [3:0] SHORT_QUADS = 4'hB;
    localparam int         POS_STATUS  = 28;
    localparam int         POS_SPD     = 20;
    localparam int         POS_FOLLOW  = 14;
    localparam int         POS_TLABEL  = 8;
    localparam int         POS_ACK     = 0;
    localparam int         POS_TCODE   = 28;
    localparam int         POS_RT      = 26;
    localparam int         POS_PRIOR   = 22;
    localparam int         POS_RCODE   = 18;

    // ****************
    // codes
    // ****************
    localparam logic [3:0] ST_ACK_COMP     = 4'h0;
    localparam logic [3:0] ST_NO_ACK_KIND  = 4'h1;
    localparam logic [3:0] ST_ACK_ERROR    = 4'h2;
    localparam logic [3:0] ST_NO_ACK       = 4'h3;
    localparam logic [3:0] ST_BELL_IDLE    = 4'h4;
    localparam logic [3:0] ST_BELL_QUEUED  = 4'h5;
    localparam logic [3:0] ST_RETRY_LIMIT  = 4'h7;
    localparam logic [3:0] ST_PTR_IDLE     = 4'h8;
    localparam logic [3:0] ST_PTR_QUEUED   = 4'h9;
    localparam logic [3:0] ST_RCODE_ERROR  = 4'hA;
    localparam logic [3:0] ST_SPLIT_TIMEOUT = 4'hB;
    localparam logic [3:0] ST_BUS_RESET    = 4'hC;
    localparam logic [3:0] ST_TXN_DISCARD  = 4'hD;
    localparam logic [3:0] ACK_COMPLETE    = 4'h1;
    localparam logic [3:0] ACK_PENDING     = 4'h2;
    localparam logic [3:0] ACK_BUSY_X      = 4'h4;
    localparam logic [3:0] RCODE_COMPLETE  = 4'h0;
    localparam logic [1:0] SPD_UNDEFINED   = 2'h3;
    localparam logic [1:0] SPD_S100        = 2'h0;

    typedef enum logic [2:0] {
        ORBRF_OC_ACKED, ORBRF_OC_UNACKED_KIND, ORBRF_OC_NO_ACK, ORBRF_OC_RETRY_LIMIT,
        ORBRF_OC_RESPONSE, ORBRF_OC_SPLIT_TIMEOUT, ORBRF_OC_BUS_RESET, ORBRF_OC_TXN_RESET
    } orbrf_outcome_t;

    typedef enum logic [1:0] {
        ORBRF_REQ_PLAIN, ORBRF_REQ_DOORBELL, ORBRF_REQ_ORB_POINTER
    } orbrf_req_t;

    typedef struct packed {
        logic                    to_cmd;
        orbrf_outcome_t          outcome;
        orbrf_req_t              req;
        logic                    next_orb_null;
        logic                    followon_queued;
        logic [5:0]              followon_label;
        logic [1:0]              spd;
        logic [5:0]              tlabel;
        logic [1:0]              rt;
        logic [3:0]              tcode;
        logic [3:0]              ack;
        logic [3:0]              rcode;
        logic [9:0]              bus;
        logic [5:0]              node;
        logic [15:0]             off_hi;
        logic [31:0]             off_lo;
        logic [ORB_QUADS*32-1:0] orb;
    } orbrf_event_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } orbrf_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } orbrf_wb_rsp_t;

endpackage

// File: src/orbrf_framer.sv
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/100ps
module orbrf_framer (
    // clock and reset
    input  wire logic                   CLK_SYS_I,
    input  wire logic                   RST_I,
    // register bus
    input  wire orbrf_pkg::orbrf_wb_req_t WB_I,
    output      orbrf_pkg::orbrf_wb_rsp_t WB_O,
    // completion events
    input  wire logic                   EV_VALID_I,
    input  wire orbrf_pkg::orbrf_event_t  EV_I,
    output      logic                   EV_READY_O,
    // discard requests to transaction engine
    output      logic                   TXN_RESET_O,
    output      logic                   TX_FIFO_CLEAR_O
);
    import orbrf_pkg::*;

    typedef enum {ORBRF_IDLE, ORBRF_WRITE} orbrf_state_t;

    // ****************
    // declarations
    // ****************
    orbrf_state_t   state_q;
    orbrf_event_t   ev_q;
    logic [31:0]    hdr_d;
    logic [31:0]    hdr_q;
    logic [3:0]     st_d;
    logic           queued_d;
    logic [5:0]     follow_d;
    logic [1:0]     spd_d;
    logic           short_q;
    logic [3:0]     idx_q;
    logic [3:0]     qsel;
    logic [3:0]     last_idx;
    logic [31:0]    quad;
    logic [2:0]     fetch_ctrl_q;
    logic           accept;
    logic           acc;
    logic           ack_q;
    logic [31:0]    rdat_q;
    logic           txn_reset_q;
    logic           tx_clear_q;
    logic [1:0]     wr_en;
    logic [1:0]     pop;
    logic [1:0]     full;
    logic [1:0]     empty;
    logic [31:0]    rd_data [2];
    logic [5:0]     level [2];
    logic           cur_full;

    // ****************
    // status code
    // ****************
    always_comb begin
        st_d     = ST_ACK_COMP;
        queued_d = 1'b0;
        case (EV_I.outcome)
            ORBRF_OC_ACKED: begin
                if (EV_I.ack == ACK_COMPLETE) begin
                    st_d = ST_ACK_COMP;
                end else if (EV_I.ack != ACK_BUSY_X && EV_I.ack != ACK_PENDING) begin
                    st_d = ST_ACK_ERROR;
                end
            end
            ORBRF_OC_UNACKED_KIND:  st_d = ST_NO_ACK_KIND;
            ORBRF_OC_NO_ACK:        st_d = ST_NO_ACK;
            ORBRF_OC_RETRY_LIMIT:   st_d = ST_RETRY_LIMIT;
            ORBRF_OC_SPLIT_TIMEOUT: st_d = ST_SPLIT_TIMEOUT;
            ORBRF_OC_BUS_RESET:     st_d = ST_BUS_RESET;
            ORBRF_OC_TXN_RESET:     st_d = ST_TXN_DISCARD;
            ORBRF_OC_RESPONSE: begin
                if (EV_I.rcode != RCODE_COMPLETE) begin
                    st_d = ST_RCODE_ERROR;
                end else begin
                    case (EV_I.req)
                        ORBRF_REQ_DOORBELL: begin
                            queued_d = EV_I.followon_queued;
                            st_d     = queued_d ? ST_BELL_QUEUED : ST_BELL_IDLE;
                        end
                        ORBRF_REQ_ORB_POINTER: begin
                            queued_d = !EV_I.next_orb_null && fetch_ctrl_q[BIT_CONT_FETCH];
                            st_d     = queued_d ? ST_PTR_QUEUED : ST_PTR_IDLE;
                        end
                        default: st_d = ST_ACK_COMP;
                    endcase
                end
            end
            default: st_d = ST_NO_ACK;
        endcase
    end

    // ****************
    // header quadlet
    // ****************
    always_comb begin
        follow_d = (EV_I.to_cmd && queued_d) ? EV_I.followon_label : 6'h00;
        spd_d    = (EV_I.spd == SPD_UNDEFINED) ? SPD_S100 : EV_I.spd;
        hdr_d                             = 32'h0000_0000;
        hdr_d[POS_STATUS +: 4]            = st_d;
        hdr_d[POS_SPD +: 2]               = spd_d;
        hdr_d[POS_FOLLOW +: 6]            = follow_d;
        hdr_d[POS_TLABEL +: 6]            = EV_I.tlabel;
        hdr_d[POS_ACK +: 4]               = EV_I.ack;
    end

    // ****************
    // record sequencer
    // ****************
    assign accept     = EV_VALID_I && EV_READY_O;
    assign EV_READY_O = (state_q == ORBRF_IDLE);
    assign cur_full   = ev_q.to_cmd ? full[1] : full[0];
    assign last_idx   = short_q ? SHORT_QUADS - 4'h1 : LONG_QUADS - 4'h1;
    assign qsel       = (short_q && idx_q != 4'h0) ? idx_q + 4'h1 : idx_q;

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            state_q <= ORBRF_IDLE;
            idx_q   <= 4'h0;
        end else begin
            case (state_q)
                ORBRF_IDLE: begin
                    idx_q <= 4'h0;
                    if (accept) begin
                        state_q <= ORBRF_WRITE;
                    end
                end
                ORBRF_WRITE: begin
                    if (!cur_full) begin
                        if (idx_q == last_idx) begin
                            state_q <= ORBRF_IDLE;
                            idx_q   <= 4'h0;
                        end else begin
                            idx_q <= idx_q + 4'h1;
                        end
                    end
                end
                default: state_q <= ORBRF_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            ev_q    <= '0;
            hdr_q   <= 32'h0000_0000;
            short_q <= 1'b0;
        end else if (accept) begin
            ev_q    <= EV_I;
            hdr_q   <= hdr_d;
            short_q <= EV_I.to_cmd ? fetch_ctrl_q[BIT_CMD_SHORT]
                                   : fetch_ctrl_q[BIT_MGMT_SHORT];
        end
    end

    // ****************
    // quadlet select
    // ****************
    always_comb begin
        quad = 32'h0000_0000;
        case (qsel)
            4'h0: quad = hdr_q;
            4'h1: begin
                quad[POS_TCODE +: 4] = ev_q.tcode;
                quad[POS_RT +: 2]    = ev_q.rt;
                quad[POS_PRIOR +: 4] = 4'h0;
                quad[POS_RCODE +: 4] = ev_q.rcode;
            end
            4'h2: quad = {ev_q.bus, ev_q.node, ev_q.off_hi};
            4'h3: quad = ev_q.off_lo;
            default: begin
                quad = ev_q.orb[(ORB_QUADS - 1 - (int'(qsel) - 4)) * 32 +: 32];
            end
        endcase
    end

    assign wr_en[0] = (state_q == ORBRF_WRITE) && !ev_q.to_cmd && !full[0];
    assign wr_en[1] = (state_q == ORBRF_WRITE) && ev_q.to_cmd && !full[1];

    // ****************
    // receive fifos
    // ****************
    for (genvar f = 0; f < 2; f++) begin : g_fifo
        logic [31:0] mem [FIFO_DEPTH];
        logic [4:0]  wp_q;
        logic [4:0]  rp_q;
        logic [5:0]  cnt_q;

        assign full[f]    = (cnt_q == 6'(FIFO_DEPTH));
        assign empty[f]   = (cnt_q == 6'h00);
        assign rd_data[f] = mem[rp_q];
        assign level[f]   = cnt_q;

        always_ff @(posedge CLK_SYS_I) begin
            if (wr_en[f]) begin
                mem[wp_q] <= quad;
            end
        end

        always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
            if (RST_I) begin
                wp_q  <= 5'h00;
                rp_q  <= 5'h00;
                cnt_q <= 6'h00;
            end else begin
                if (wr_en[f]) begin
                    wp_q <= wp_q + 5'h01;
                end
                if (pop[f]) begin
                    rp_q <= rp_q + 5'h01;
                end
                case ({wr_en[f], pop[f]})
                    2'b10:   cnt_q <= cnt_q + 6'h01;
                    2'b01:   cnt_q <= cnt_q - 6'h01;
                    default: cnt_q <= cnt_q;
                endcase
            end
        end
    end

    // ****************
    // register bus
    // ****************
    assign acc    = WB_I.cyc && WB_I.stb && !ack_q;
    assign pop[0] = acc && !WB_I.we && WB_I.adr == ADR_MGMT_READ && !empty[0];
    assign pop[1] = acc && !WB_I.we && WB_I.adr == ADR_CMD_READ && !empty[1];

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= acc;
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            rdat_q <= 32'h0000_0000;
        end else if (acc) begin
            rdat_q <= 32'h0000_0000;
            if (!WB_I.we) begin
                case (WB_I.adr)
                    ADR_FETCH_CTRL: rdat_q[2:0] <= fetch_ctrl_q;
                    ADR_MGMT_READ:  rdat_q <= empty[0] ? 32'h0000_0000 : rd_data[0];
                    ADR_CMD_READ:   rdat_q <= empty[1] ? 32'h0000_0000 : rd_data[1];
                    ADR_LEVEL: begin
                        rdat_q[5:0]                    <= level[0];
                        rdat_q[POS_CMD_LEVEL +: 6]     <= level[1];
                    end
                    default: rdat_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            fetch_ctrl_q <= FETCH_CTRL_RST;
        end else if (acc && WB_I.we && WB_I.sel[0] && WB_I.adr == ADR_FETCH_CTRL) begin
            fetch_ctrl_q <= WB_I.dat[2:0];
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            txn_reset_q <= 1'b0;
            tx_clear_q  <= 1'b0;
        end else begin
            txn_reset_q <= acc && WB_I.we && WB_I.sel[0] && WB_I.adr == ADR_TXN_CTRL
                           && WB_I.dat[BIT_TXN_RESET];
            tx_clear_q  <= acc && WB_I.we && WB_I.sel[0] && WB_I.adr == ADR_TXN_CTRL
                           && WB_I.dat[BIT_TX_CLEAR];
        end
    end

    assign WB_O.ack        = ack_q;
    assign WB_O.dat        = rdat_q;
    assign TXN_RESET_O     = txn_reset_q;
    assign TX_FIFO_CLEAR_O = tx_clear_q;

    // ****************
    // checks
    // ****************
    AST_COMP_ZERO: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        accept && EV_I.outcome == ORBRF_OC_ACKED && EV_I.ack == ACK_COMPLETE
        |=> hdr_q[POS_STATUS +: 4] == ST_ACK_COMP)
        else $error("ack complete not coded zero");

    AST_NO_ACK_THREE: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        accept && EV_I.outcome == ORBRF_OC_NO_ACK |=> hdr_q[POS_STATUS +: 4] == ST_NO_ACK)
        else $error("missing ack not coded three");

    AST_RETRY_SEVEN: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        accept && EV_I.outcome == ORBRF_OC_RETRY_LIMIT
        |=> hdr_q[POS_STATUS +: 4] == ST_RETRY_LIMIT)
        else $error("retry limit not coded seven");

    AST_PTR_QUEUED: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        accept && EV_I.outcome == ORBRF_OC_RESPONSE && EV_I.rcode == RCODE_COMPLETE
        && EV_I.req == ORBRF_REQ_ORB_POINTER
        |=> hdr_q[POS_STATUS +: 4] == ($past(EV_I.next_orb_null)
            || !$past(fetch_ctrl_q[BIT_CONT_FETCH]) ? ST_PTR_IDLE : ST_PTR_QUEUED))
        else $error("pointer write status wrong");

    AST_MGMT_NO_FOLLOW: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        wr_en[0] && idx_q == 4'h0 |-> quad[POS_FOLLOW +: 6] == 6'h00)
        else $error("follow-on label in management record");

    AST_SPD_DEFINED: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        (wr_en != 2'b00) && idx_q == 4'h0 |-> quad[POS_SPD +: 2] != SPD_UNDEFINED)
        else $error("undefined speed recorded");

    AST_RESERVED_CODES: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        state_q == ORBRF_WRITE |-> hdr_q[POS_STATUS +: 4] != 4'h6
        && hdr_q[POS_STATUS +: 4] < 4'hE)
        else $error("reserved status code");

    AST_RECORD_LEN: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        accept && !EV_I.to_cmd && !fetch_ctrl_q[BIT_MGMT_SHORT] && level[0] == 6'h00
        && !pop[0] ##1 (!pop[0])[*8] |-> level[0] == 6'h07)
        else $error("long record not written one quadlet per cycle");

    AST_BUS_ACK: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        WB_I.cyc && WB_I.stb && !ack_q |=> ack_q ##1 !ack_q)
        else $error("bus answer not a single cycle");

    AST_TXN_PULSE: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        acc && WB_I.we && WB_I.sel[0] && WB_I.adr == ADR_TXN_CTRL && WB_I.dat[BIT_TXN_RESET]
        |=> TXN_RESET_O ##1 !TXN_RESET_O)
        else $error("transaction reset pulse missing");

endmodule // orbrf_framer

// File: verification/orbrf_host_model.sv
`timescale 1ns/100ps
module orbrf_host_model (
    // clock
    input  wire logic                     clk_i,
    // register bus
    input  wire orbrf_pkg::orbrf_wb_rsp_t rsp_i,
    output      orbrf_pkg::orbrf_wb_req_t req_o
);
    import orbrf_pkg::*;

    // ****************
    // classic single cycle master
    // ****************
    initial req_o = '0;

    task automatic access(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                          output logic [31:0] rd);
        @(posedge clk_i);
        req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: wd};
        @(posedge clk_i);
        while (rsp_i.ack !== 1'b1) @(posedge clk_i);
        rd = rsp_i.dat;
        req_o <= '0;
    endtask

    task automatic bus_wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] unused;
        access(1'b1, adr, dat, unused);
    endtask

    // record quadlets are popped one per read
    task automatic bus_rd(input logic [7:0] adr, output logic [31:0] dat);
        access(1'b0, adr, 32'h0, dat);
    endtask
endmodule // orbrf_host_model

// File: verification/tb_orb_receive_record_long_format.sv
`timescale 1ns/100ps
module tb_orb_receive_record_long_format;
    import orbrf_pkg::*;

    // flags: next_orb_null, followon_queued, to_cmd, continuous fetch, short select
    typedef struct packed {
        orbrf_outcome_t oc;
        orbrf_req_t     rq;
        logic [3:0]     ak;
        logic [3:0]     rc;
        logic [4:0]     fl;
        logic [3:0]     st;
    } orbrf_row_t;

    logic          clk;
    logic          rst;
    orbrf_wb_req_t wb_req;
    orbrf_wb_rsp_t wb_rsp;
    logic          ev_valid;
    orbrf_event_t  ev_d;
    logic          ev_ready;
    logic          txn_reset;
    logic          tx_clear;
    orbrf_row_t    rows [18];
    int            bad_count;
    int            comparisons;
    int            n_rst;
    int            n_clr;

    orbrf_framer i_orbrf_framer (
        .CLK_SYS_I       (clk),
        .RST_I           (rst),
        .WB_I            (wb_req),
        .WB_O            (wb_rsp),
        .EV_VALID_I      (ev_valid),
        .EV_I            (ev_d),
        .EV_READY_O      (ev_ready),
        .TXN_RESET_O     (txn_reset),
        .TX_FIFO_CLEAR_O (tx_clear)
    );

    orbrf_host_model i_orbrf_host_model (
        .clk_i (clk),
        .rsp_i (wb_rsp),
        .req_o (wb_req)
    );

    initial clk = 1'b0;
    always #50 clk = ~clk;

    always @(posedge clk) begin
        if (txn_reset === 1'b1) n_rst++;
        if (tx_clear === 1'b1) n_clr++;
    end

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        wrap_up();
    end

    // ****************
    // helpers
    // ****************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    function automatic orbrf_event_t mk(input int i, input orbrf_row_t r);
        orbrf_event_t e;
        e                 = '0;
        e.to_cmd          = r.fl[2];
        e.outcome         = r.oc;
        e.req             = r.rq;
        e.next_orb_null   = r.fl[4];
        e.followon_queued = r.fl[3];
        e.followon_label  = 6'h2A ^ i[5:0];
        e.spd             = i[1:0];
        e.tlabel          = i[5:0];
        e.rt              = ~i[1:0];
        e.tcode           = 4'h9 ^ i[3:0];
        e.ack             = r.ak;
        e.rcode           = r.rc;
        e.bus             = 10'h2C5;
        e.node            = 6'h1B ^ i[5:0];
        e.off_hi          = 16'hF0F0 ^ i[15:0];
        e.off_lo          = 32'h12345678 ^ 32'(i);
        for (int k = 0; k < ORB_QUADS; k++) e.orb[k * 32 +: 32] = {8'hA5, i[7:0], 8'h0, k[7:0]};
        return e;
    endfunction

    function automatic logic [31:0] exp_q(input int k, input orbrf_event_t e,
                                          input logic [3:0] st, input logic sh);
        int         kk;
        logic [5:0] fol;
        kk  = (sh && k > 0) ? k + 1 : k;
        fol = (e.to_cmd && (st == ST_BELL_QUEUED || st == ST_PTR_QUEUED)) ? e.followon_label
                                                                           : 6'h0;
        case (kk)
            0: return {st, 6'h0, (e.spd == SPD_UNDEFINED) ? SPD_S100 : e.spd, fol, e.tlabel,
                       4'h0, e.ack};
            1: return {e.tcode, e.rt, 4'h0, e.rcode, 18'h0};
            2: return {e.bus, e.node, e.off_hi};
            3: return e.off_lo;
            default: return e.orb[(11 - kk) * 32 +: 32];
        endcase
    endfunction

    task automatic send(input orbrf_event_t e);
        @(posedge clk);
        ev_valid <= 1'b1;
        ev_d     <= e;
        @(posedge clk);
        while (ev_ready !== 1'b1) @(posedge clk);
        ev_valid <= 1'b0;
        @(posedge clk);
        while (ev_ready !== 1'b1) @(posedge clk);
    endtask

    task automatic check_rec(input orbrf_event_t e, input logic [3:0] st, input logic sh);
        logic [31:0] d;
        logic [31:0] x;
        for (int k = 0; k < (sh ? 11 : 12); k++) begin
            i_orbrf_host_model.bus_rd(e.to_cmd ? ADR_CMD_READ : ADR_MGMT_READ, d);
            x = exp_q(k, e, st, sh);
            if (k == 0) chk("record header", x, d);
            else chk("record quadlet", x, d);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ****************
    // sequence
    // ****************
    initial begin
        orbrf_event_t e;
        logic [31:0]  d;
        logic [3:0]   n;
        rst      = 1'b1;
        ev_valid = 1'b0;
        ev_d     = '0;
        rows[0]  = '{ORBRF_OC_ACKED, ORBRF_REQ_PLAIN, 4'h1, 4'h0, 5'h00, 4'h0};
        rows[1]  = '{ORBRF_OC_ACKED, ORBRF_REQ_PLAIN, 4'h4, 4'h0, 5'h04, 4'h0};
        rows[2]  = '{ORBRF_OC_ACKED, ORBRF_REQ_PLAIN, 4'h2, 4'h0, 5'h00, 4'h0};
        rows[3]  = '{ORBRF_OC_ACKED, ORBRF_REQ_PLAIN, 4'hD, 4'h0, 5'h04, 4'h2};
        rows[4]  = '{ORBRF_OC_UNACKED_KIND, ORBRF_REQ_PLAIN, 4'h0, 4'h0, 5'h00, 4'h1};
        rows[5]  = '{ORBRF_OC_NO_ACK, ORBRF_REQ_PLAIN, 4'h0, 4'h0, 5'h01, 4'h3};
        rows[6]  = '{ORBRF_OC_RESPONSE, ORBRF_REQ_DOORBELL, 4'h1, 4'h0, 5'h04, 4'h4};
        rows[7]  = '{ORBRF_OC_RESPONSE, ORBRF_REQ_DOORBELL, 4'h1, 4'h0, 5'h0C, 4'h5};
        rows[8]  = '{ORBRF_OC_RESPONSE, ORBRF_REQ_DOORBELL, 4'h1, 4'h0, 5'h08, 4'h5};
        rows[9]  = '{ORBRF_OC_RETRY_LIMIT, ORBRF_REQ_PLAIN, 4'h4, 4'h0, 5'h00, 4'h7};
        rows[10] = '{ORBRF_OC_RESPONSE, ORBRF_REQ_ORB_POINTER, 4'h1, 4'h0, 5'h16, 4'h8};
        rows[11] = '{ORBRF_OC_RESPONSE, ORBRF_REQ_ORB_POINTER, 4'h1, 4'h0, 5'h04, 4'h8};
        rows[12] = '{ORBRF_OC_RESPONSE, ORBRF_REQ_ORB_POINTER, 4'h1, 4'h0, 5'h07, 4'h9};
        rows[13] = '{ORBRF_OC_RESPONSE, ORBRF_REQ_DOORBELL, 4'h1, 4'h6, 5'h0C, 4'hA};
        rows[14] = '{ORBRF_OC_SPLIT_TIMEOUT, ORBRF_REQ_PLAIN, 4'h1, 4'h0, 5'h00, 4'hB};
        rows[15] = '{ORBRF_OC_BUS_RESET, ORBRF_REQ_PLAIN, 4'h1, 4'h0, 5'h04, 4'hC};
        rows[16] = '{ORBRF_OC_TXN_RESET, ORBRF_REQ_PLAIN, 4'h1, 4'h0, 5'h00, 4'hD};
        rows[17] = '{ORBRF_OC_RESPONSE, ORBRF_REQ_PLAIN, 4'h1, 4'h0, 5'h00, 4'h0};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("ready after reset", 32'h1, {31'h0, ev_ready});
        i_orbrf_host_model.bus_rd(ADR_FETCH_CTRL, d);
        chk("fetch control reset", {29'h0, FETCH_CTRL_RST}, d);
        i_orbrf_host_model.bus_rd(8'hF0, d);
        chk("unmapped read", 32'h0, d);
        for (int i = 0; i < 18; i++) begin
            e = mk(i, rows[i]);
            i_orbrf_host_model.bus_wr(ADR_FETCH_CTRL, {29'h0, rows[i].fl[1],
                rows[i].fl[0] & rows[i].fl[2], rows[i].fl[0] & ~rows[i].fl[2]});
            send(e);
            n = rows[i].fl[0] ? SHORT_QUADS : LONG_QUADS;
            i_orbrf_host_model.bus_rd(ADR_LEVEL, d);
            chk("fifo level", rows[i].fl[2] ? {12'h0, n, 16'h0} : {28'h0, n}, d);
            check_rec(e, rows[i].st, rows[i].fl[0]);
            i_orbrf_host_model.bus_rd(rows[i].fl[2] ? ADR_CMD_READ : ADR_MGMT_READ, d);
            chk("empty read", 32'h0, d);
        end
        // back to back records into one fifo
        i_orbrf_host_model.bus_wr(ADR_FETCH_CTRL, 32'h0);
        send(mk(20, rows[0]));
        send(mk(21, rows[4]));
        i_orbrf_host_model.bus_rd(ADR_LEVEL, d);
        chk("level two records", 32'h18, d);
        check_rec(mk(20, rows[0]), 4'h0, 1'b0);
        check_rec(mk(21, rows[4]), 4'h1, 1'b0);
        // discard requests
        i_orbrf_host_model.bus_wr(ADR_TXN_CTRL, 32'h1);
        i_orbrf_host_model.bus_wr(ADR_TXN_CTRL, 32'h2);
        i_orbrf_host_model.bus_wr(ADR_TXN_CTRL, 32'h3);
        repeat (2) @(posedge clk);
        chk("transaction reset pulses", 32'h2, 32'(n_rst));
        chk("tx fifo clear pulses", 32'h2, 32'(n_clr));
        i_orbrf_host_model.bus_rd(ADR_TXN_CTRL, d);
        chk("discard bits read", 32'h0, d);
        // reset while a record is being written
        @(posedge clk);
        ev_valid <= 1'b1;
        ev_d     <= mk(30, rows[0]);
        @(posedge clk);
        ev_valid <= 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("ready after mid reset", 32'h1, {31'h0, ev_ready});
        i_orbrf_host_model.bus_rd(ADR_LEVEL, d);
        chk("level after mid reset", 32'h0, d);
        wrap_up();
    end
endmodule // tb_orb_receive_record_long_format
